// *** bench/ftdb_top_tb_top.sv ***
// Self-checking bench for the frame-trigger block: APB set-up and trigger scenarios.
// Assumes the trigger source model drives the line clock and the IO trigger pin.
`timescale 1ns/10ps
`default_nettype none
module ftdb_top_tb_top;
   import ftdb_pkg::*;
   logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, lineClk, ioTrigIn, imageTrigIn = 1'b0, lvl = 1'b0;
   logic frameActive, imageStart, imageEnd, lineCapture, trigFiltered;
   logic [33:0] apbQ[$];
   logic [15:0] frameQ[$];
   logic [15:0] lines = 16'h0, nxt, len, dly;
   int failures = 0, checked = 0, images = 0, seed = 40624;
   ftdb_top u_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .lineClk(lineClk), .ioTrigIn(ioTrigIn), .imageTrigIn(imageTrigIn),
      .frameActive(frameActive), .imageStart(imageStart), .imageEnd(imageEnd),
      .lineCapture(lineCapture), .trigFiltered(trigFiltered));
   ftdb_trig_src u_src (.level(lvl), .lineClk(lineClk), .trigPin(ioTrigIn));
   always #5 sys_clk = ~sys_clk;
   // ==========================================================
   // Checking
   // ==========================================================
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Each answer or finished image takes the oldest note off its queue.
   always @(posedge sys_clk) begin
      if (pready === 1'b1) begin
         if (apbQ.size() == 0) begin
            failures++;
         end else begin
            check({31'h0, pslverr}, {31'h0, apbQ[0][32]});
            if (apbQ[0][33]) begin
               check(prdata, apbQ[0][31:0]);
            end
            void'(apbQ.pop_front());
         end
      end
      nxt = (imageStart === 1'b1) ? 16'h0 : lines;
      nxt = nxt + {15'h0, lineCapture === 1'b1};
      if (imageStart === 1'b1) begin
         check({31'h0, frameActive}, 32'h1);
      end
      if (imageEnd === 1'b1) begin
         images++;
         check({31'h0, frameActive}, 32'h0);
         if (frameQ.size() == 0) begin
            failures++;
         end else begin
            if (frameQ[0] != 16'hffff) begin
               check({16'h0, nxt}, {16'h0, frameQ[0]});
            end
            void'(frameQ.pop_front());
         end
      end
      lines <= nxt;
   end
   // ==========================================================
   // Drivers
   // ==========================================================
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [33:0] exp);
      int i;
      apbQ.push_back(exp);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (pready === 1'b1) break;
      end
      if (i == 50) begin
         failures++;
         tally_and_finish();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 34'h0);
   endtask
   task automatic line_wait(input int n);
      repeat (n) @(posedge lineClk);
      @(posedge sys_clk);
   endtask
   task automatic wait_images(input int n);
      int i;
      for (i = 0; i < 30000 && images < n; i++) @(posedge sys_clk);
      if (images < n) begin
         failures++;
         tally_and_finish();
      end
   endtask
   task automatic pulse_io(input int hi);
      lvl <= 1'b1;
      line_wait(hi);
      lvl <= 1'b0;
   endtask
   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      repeat (12) @(posedge sys_clk);
      arst_n <= 1'b1;
      len = 16'h18 + 16'($unsigned($random(seed)) % 4);
      dly = 16'($unsigned($random(seed)) % 4);
      // Reset values, an unmapped place and a read-back.
      apb(1'b0, FTDB_CTRL_OFS, 32'h0, {2'b10, 32'h10});
      apb(1'b0, FTDB_LENGTH_OFS, 32'h0, {2'b10, 32'h100});
      apb(1'b0, 8'h18, 32'h0, {2'b01, 32'h0});
      apb(1'b1, 8'h18, 32'h5, {2'b01, 32'h0});
      wr(FTDB_DELAY_OFS, {16'h0, dly});
      apb(1'b0, FTDB_DELAY_OFS, 32'h0, {2'b10, 16'h0, dly});
      wr(FTDB_LENGTH_OFS, {16'h0, len});
      // IO pin, fast filter, rising edge, start only; a second edge falls inside the image.
      wr(FTDB_CTRL_OFS, 32'h35);
      frameQ.push_back(len);
      pulse_io(10);
      line_wait(10);
      pulse_io(10);
      wait_images(1);
      line_wait(16);
      check(images, 1);
      // Falling edge with the middle filter: the rising edge must not start anything.
      wr(FTDB_CTRL_OFS, 32'h29);
      frameQ.push_back(len);
      lvl <= 1'b1;
      line_wait(12);
      check(images, 1);
      lvl <= 1'b0;
      wait_images(2);
      line_wait(14);
      // Image source, very long filter, start-stop: a dropout keeps one image.
      wr(FTDB_CTRL_OFS, 32'h5e);
      frameQ.push_back(16'hffff);
      imageTrigIn <= 1'b1;
      line_wait(80);
      imageTrigIn <= 1'b0;
      line_wait(20);
      imageTrigIn <= 1'b1;
      line_wait(80);
      imageTrigIn <= 1'b0;
      wait_images(3);
      line_wait(70);
      check(images, 3);
      // Start-stop with the length ceiling on a long trigger.
      wr(FTDB_CTRL_OFS, 32'hb6);
      frameQ.push_back(len);
      pulse_io(40);
      wait_images(4);
      line_wait(8);
      // Start-stop with lines after stop: twelve trigger lines less the delay, then five more.
      wr(FTDB_AFTER_OFS, 32'h5);
      wr(FTDB_CTRL_OFS, 32'h136);
      frameQ.push_back(16'hc - dly + 16'h5);
      pulse_io(12);
      wait_images(5);
      line_wait(8);
      // Peak hold on a grabber bit pulse of a few clocks.
      wr(FTDB_LENGTH_OFS, 32'h1);
      wr(FTDB_CTRL_OFS, 32'h11);
      frameQ.push_back(16'h1);
      wr(FTDB_GRABBER_OFS, 32'h1);
      wr(FTDB_GRABBER_OFS, 32'h0);
      line_wait(5);
      check({31'h0, trigFiltered}, 32'h1);
      line_wait(8);
      check({31'h0, trigFiltered}, 32'h0);
      wait_images(6);
      // Frame mode off: a trigger starts no image.
      wr(FTDB_CTRL_OFS, 32'h34);
      pulse_io(10);
      line_wait(20);
      check(images, 6);
      check({31'h0, frameActive}, 32'h0);
      check(frameQ.size(), 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// *** bench/ftdb_trig_src.sv ***
// Model of the outside trigger source: a light barrier or encoder with its line clock.
// Assumes the bench sets the wanted level; the source moves only at line starts.
`timescale 1ns/10ps
`default_nettype none
module ftdb_trig_src
(
   input wire logic level,
   output logic lineClk,
   output logic trigPin
);
   initial begin
      lineClk = 1'b0;
      trigPin = 1'b0;
   end
   // ==========================================================
   // Line clock
   // ==========================================================
   // The line clock runs free, unrelated in phase to the system clock.
   always #103 lineClk = ~lineClk;
   // The level changes only at a line start, so every state lasts whole lines.
   always @(posedge lineClk) trigPin <= level;
endmodule
`default_nettype wire

// *** src/ftdb_pkg.sv ***
// Constants and types for the frame-trigger debounce and edge block.
// Assumes a 100 MHz system clock and a 32-bit APB register bus.
package ftdb_pkg;

   // ==========================================================
   // Register map (byte addresses)
   // ==========================================================
   localparam logic [7:0] FTDB_CTRL_OFS = 8'h00;
   localparam logic [7:0] FTDB_DELAY_OFS = 8'h04;
   localparam logic [7:0] FTDB_LENGTH_OFS = 8'h08;
   localparam logic [7:0] FTDB_AFTER_OFS = 8'h0c;
   localparam logic [7:0] FTDB_GRABBER_OFS = 8'h10;
   localparam logic [7:0] FTDB_STATUS_OFS = 8'h14;

   // ==========================================================
   // Control register fields
   // ==========================================================
   localparam int FTDB_MODE_POS = 0;
   localparam int FTDB_DEB_POS = 2;
   localparam int FTDB_EDGE_POS = 4;
   localparam int FTDB_SRC_POS = 5;
   localparam int FTDB_MAXEN_POS = 7;
   localparam int FTDB_AFTEREN_POS = 8;
   localparam int FTDB_CTRL_W = 9;
   localparam logic [8:0] FTDB_CTRL_RST = 9'h010;
   localparam logic [15:0] FTDB_DELAY_RST = 16'h0000;
   localparam logic [15:0] FTDB_LENGTH_RST = 16'h0100;
   localparam logic [15:0] FTDB_AFTER_RST = 16'h0000;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam logic [5:0] FTDB_FAST_CYC = 6'h04;
   localparam logic [5:0] FTDB_MIDDLE_LINES = 6'h04;
   localparam logic [5:0] FTDB_LONG_LINES = 6'h3c;
   localparam logic [5:0] FTDB_PEAK_LINES = 6'h0a;

   // ==========================================================
   // Enumerations
   // ==========================================================
   typedef enum logic [1:0] {
      FRAME_OFF = 2'h0,
      FRAME_START_ONLY = 2'h1,
      FRAME_START_STOP = 2'h2,
      FRAME_RSVD = 2'h3
   } ftdb_frame_t;

   typedef enum logic [1:0] {
      DEBOUNCE_PEAK_HOLD = 2'h0,
      DEBOUNCE_FAST = 2'h1,
      DEBOUNCE_MIDDLE = 2'h2,
      DEBOUNCE_VERY_LONG = 2'h3
   } ftdb_deb_t;

   typedef enum logic [1:0] {
      SRC_GRABBER = 2'h0,
      SRC_IO_PIN = 2'h1,
      SRC_IMAGE = 2'h2,
      SRC_NONE = 2'h3
   } ftdb_src_t;

   typedef enum logic [3:0] {
      FT_IDLE = 4'b0001,
      FT_DELAY = 4'b0010,
      FT_ACQ = 4'b0100,
      FT_TAIL = 4'b1000
   } ftdb_state_t;

endpackage

// *** src/ftdb_top.sv ***
// Frame-trigger conditioning: source select, debounce, edge select and image framing.
// Assumes an APB master on sys_clk; lineClk and ioTrigIn arrive from outside.
`timescale 1ns/10ps
`default_nettype none

module ftdb_top
   import ftdb_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic lineClk,
   input wire logic ioTrigIn,
   input wire logic imageTrigIn,
   output logic frameActive,
   output logic imageStart,
   output logic imageEnd,
   output logic lineCapture,
   output logic trigFiltered
);
   import ftdb_pkg::*;

   // ==========================================================
   // Registers and wires
   // ==========================================================
   logic [FTDB_CTRL_W-1:0] ctrl_r;
   logic [15:0] delay_r;
   logic [15:0] length_r;
   logic [15:0] after_r;
   logic grabberBit_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic ioSync1_r, ioSync2_r;
   logic lineSync1_r, lineSync2_r, lineSync3_r;
   logic flt_r, flt_nxt, fltPrev_r;
   logic [5:0] dbCnt_r, dbCnt_nxt;
   ftdb_state_t state_r, state_nxt;
   logic [15:0] lineCnt_r, lineCnt_nxt;
   logic frameActive_r, imageStart_r, imageEnd_r, lineCapture_r;

   wire ftdb_frame_t frameMode = ftdb_frame_t'(ctrl_r[FTDB_MODE_POS +: 2]);
   wire ftdb_deb_t debMode = ftdb_deb_t'(ctrl_r[FTDB_DEB_POS +: 2]);
   wire ftdb_src_t srcSel = ftdb_src_t'(ctrl_r[FTDB_SRC_POS +: 2]);
   wire logic edgeRise = ctrl_r[FTDB_EDGE_POS];
   wire logic maxEn = ctrl_r[FTDB_MAXEN_POS];
   wire logic afterEn = ctrl_r[FTDB_AFTEREN_POS];

   // Number of agreeing samples a debounce mode needs before a level is accepted.
   function automatic logic [5:0] dbNeed(input ftdb_deb_t m);
      case (m)
         DEBOUNCE_FAST: dbNeed = FTDB_FAST_CYC;
         DEBOUNCE_MIDDLE: dbNeed = FTDB_MIDDLE_LINES;
         DEBOUNCE_VERY_LONG: dbNeed = FTDB_LONG_LINES;
         default: dbNeed = FTDB_PEAK_LINES;
      endcase
   endfunction

   // ==========================================================
   // APB slave: one wait state, errors on unmapped addresses
   // ==========================================================
   wire logic accSetup = psel & penable & ~pready_r;
   wire logic wrEn = psel & penable & pready_r & pwrite & ~pslverr_r;
   wire logic hit = (paddr == FTDB_CTRL_OFS) || (paddr == FTDB_DELAY_OFS) ||
                    (paddr == FTDB_LENGTH_OFS) || (paddr == FTDB_AFTER_OFS) ||
                    (paddr == FTDB_GRABBER_OFS) || (paddr == FTDB_STATUS_OFS);
   wire logic [31:0] statusWord = {8'h00, 3'h0, flt_r, state_r, lineCnt_r};
   wire logic [31:0] readMux =
      (paddr == FTDB_CTRL_OFS) ? {23'h000000, ctrl_r} :
      (paddr == FTDB_DELAY_OFS) ? {16'h0000, delay_r} :
      (paddr == FTDB_LENGTH_OFS) ? {16'h0000, length_r} :
      (paddr == FTDB_AFTER_OFS) ? {16'h0000, after_r} :
      (paddr == FTDB_GRABBER_OFS) ? {31'h00000000, grabberBit_r} :
      (paddr == FTDB_STATUS_OFS) ? statusWord : 32'h00000000;

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h00000000;
      end else begin
         pready_r <= accSetup;
         pslverr_r <= accSetup & ~hit;
         if (accSetup && !pwrite) begin
            prdata_r <= readMux;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= FTDB_CTRL_RST;
         delay_r <= FTDB_DELAY_RST;
         length_r <= FTDB_LENGTH_RST;
         after_r <= FTDB_AFTER_RST;
         grabberBit_r <= 1'b0;
      end else if (wrEn) begin
         if (paddr == FTDB_CTRL_OFS) ctrl_r <= pwdata[FTDB_CTRL_W-1:0];
         if (paddr == FTDB_DELAY_OFS) delay_r <= pwdata[15:0];
         if (paddr == FTDB_LENGTH_OFS) length_r <= pwdata[15:0];
         if (paddr == FTDB_AFTER_OFS) after_r <= pwdata[15:0];
         if (paddr == FTDB_GRABBER_OFS) grabberBit_r <= pwdata[0];
      end
   end

   // ==========================================================
   // Input synchronisers and source select
   // ==========================================================
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ioSync1_r <= 1'b0;
         ioSync2_r <= 1'b0;
         lineSync1_r <= 1'b0;
         lineSync2_r <= 1'b0;
         lineSync3_r <= 1'b0;
      end else begin
         ioSync1_r <= ioTrigIn;
         ioSync2_r <= ioSync1_r;
         lineSync1_r <= lineClk;
         lineSync2_r <= lineSync1_r;
         lineSync3_r <= lineSync2_r;
      end
   end

   wire logic lineTick = lineSync2_r & ~lineSync3_r;
   wire logic rawTrig = (srcSel == SRC_GRABBER) ? grabberBit_r :
                        (srcSel == SRC_IO_PIN) ? ioSync2_r :
                        (srcSel == SRC_IMAGE) ? imageTrigIn : 1'b0;

   // ==========================================================
   // Debounce filter
   // ==========================================================
   wire logic dbTick = (debMode == DEBOUNCE_FAST) ? 1'b1 : lineTick;

   // A new debounce setting starts its window afresh instead of inheriting a count.
   wire logic debChange = wrEn && (paddr == FTDB_CTRL_OFS) &&
                          (pwdata[FTDB_DEB_POS +: 2] != ctrl_r[FTDB_DEB_POS +: 2]);
   wire logic [5:0] debRestart = (pwdata[FTDB_DEB_POS +: 2] == DEBOUNCE_PEAK_HOLD) ?
                                 FTDB_PEAK_LINES : 6'h00;

   always_comb begin
      flt_nxt = flt_r;
      dbCnt_nxt = dbCnt_r;
      if (debMode == DEBOUNCE_PEAK_HOLD) begin
         // Any active sample restarts the hold, so even one-clock peaks are caught.
         if (rawTrig) begin
            flt_nxt = 1'b1;
            dbCnt_nxt = FTDB_PEAK_LINES;
         end else if (lineTick && dbCnt_r > 6'h01) begin
            dbCnt_nxt = dbCnt_r - 6'h01;
         end else if (lineTick) begin
            flt_nxt = 1'b0;
            dbCnt_nxt = 6'h00;
         end
      end else if (dbTick) begin
         if (rawTrig == flt_r) begin
            dbCnt_nxt = 6'h00;
         end else if (dbCnt_r + 6'h01 >= dbNeed(debMode)) begin
            flt_nxt = rawTrig;
            dbCnt_nxt = 6'h00;
         end else begin
            dbCnt_nxt = dbCnt_r + 6'h01;
         end
      end
      if (debChange) begin
         dbCnt_nxt = debRestart;
      end
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flt_r <= 1'b0;
         fltPrev_r <= 1'b0;
         dbCnt_r <= 6'h00;
      end else begin
         flt_r <= flt_nxt;
         fltPrev_r <= flt_r;
         dbCnt_r <= dbCnt_nxt;
      end
   end

   // ==========================================================
   // Edge select and image framing
   // ==========================================================
   wire logic trigMode = (frameMode == FRAME_START_ONLY) || (frameMode == FRAME_START_STOP);
   wire logic fltRise = flt_r & ~fltPrev_r;
   wire logic fltFall = ~flt_r & fltPrev_r;
   wire logic startEdge = edgeRise ? fltRise : fltFall;
   wire logic trigActive = edgeRise ? flt_r : ~flt_r;
   wire logic lastLine = (lineCnt_r + 16'h0001) >= length_r;

   always_comb begin
      state_nxt = state_r;
      lineCnt_nxt = lineCnt_r;
      case (state_r)
         FT_IDLE: begin
            if (trigMode && startEdge) begin
               lineCnt_nxt = delay_r;
               state_nxt = (delay_r == 16'h0000) ? FT_ACQ : FT_DELAY;
               if (delay_r == 16'h0000) lineCnt_nxt = 16'h0000;
            end
         end
         FT_DELAY: begin
            if (lineTick && lineCnt_r <= 16'h0001) begin
               state_nxt = FT_ACQ;
               lineCnt_nxt = 16'h0000;
            end else if (lineTick) begin
               lineCnt_nxt = lineCnt_r - 16'h0001;
            end
         end
         FT_ACQ: begin
            if (frameMode == FRAME_START_ONLY) begin
               if (lineTick && lastLine) state_nxt = FT_IDLE;
               if (lineTick) lineCnt_nxt = lineCnt_r + 16'h0001;
            end else if (maxEn && lineTick && lastLine) begin
               state_nxt = FT_IDLE;
            end else if (!trigActive) begin
               state_nxt = (afterEn && after_r != 16'h0000) ? FT_TAIL : FT_IDLE;
               lineCnt_nxt = after_r;
            end else if (lineTick) begin
               lineCnt_nxt = lineCnt_r + 16'h0001;
            end
         end
         FT_TAIL: begin
            if (lineTick && lineCnt_r <= 16'h0001) begin
               state_nxt = FT_IDLE;
            end else if (lineTick) begin
               lineCnt_nxt = lineCnt_r - 16'h0001;
            end
         end
         default: begin
            state_nxt = FT_IDLE;
         end
      endcase
      if (!trigMode) begin
         state_nxt = FT_IDLE;
      end
   end

   wire logic acqNxt = (state_nxt == FT_ACQ) || (state_nxt == FT_TAIL);
   wire logic acqNow = (state_r == FT_ACQ) || (state_r == FT_TAIL);

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= FT_IDLE;
         lineCnt_r <= 16'h0000;
         frameActive_r <= 1'b0;
         imageStart_r <= 1'b0;
         imageEnd_r <= 1'b0;
         lineCapture_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         lineCnt_r <= lineCnt_nxt;
         frameActive_r <= acqNxt;
         imageStart_r <= acqNxt & ~acqNow;
         imageEnd_r <= acqNow & ~acqNxt;
         lineCapture_r <= acqNow & lineTick;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign frameActive = frameActive_r;
   assign imageStart = imageStart_r;
   assign imageEnd = imageEnd_r;
   assign lineCapture = lineCapture_r;
   assign trigFiltered = flt_r;

   // ==========================================================
   // Assertions
   // ==========================================================
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!arst_n);

   sequence fastHighRun;
      (debMode == DEBOUNCE_FAST && rawTrig && !flt_r)[*4];
   endsequence

   peak_stretch_a: assert property (
      debMode == DEBOUNCE_PEAK_HOLD && $stable(debMode) && $fell(flt_r)
      |-> $past(dbCnt_r) == 6'h01 && $past(lineTick))
      else $error("peak hold released early");
   fast_accept_a: assert property (fastHighRun |=> flt_r)
      else $error("fast debounce did not accept after four clocks");
   middle_window_a: assert property (
      debMode == DEBOUNCE_MIDDLE && $stable(debMode) && $changed(flt_r)
      |-> $past(dbCnt_r) == 6'h03)
      else $error("middle debounce window wrong");
   long_window_a: assert property (
      debMode == DEBOUNCE_VERY_LONG && $stable(debMode) && $changed(flt_r)
      |-> $past(dbCnt_r) == 6'h3b)
      else $error("long debounce window wrong");
   line_sample_a: assert property (
      (debMode == DEBOUNCE_MIDDLE || debMode == DEBOUNCE_VERY_LONG) && $stable(debMode)
      && $changed(flt_r) |-> $past(lineTick))
      else $error("filter changed off a line tick");
   hold_while_active_a: assert property (
      state_r == FT_ACQ && frameMode == FRAME_START_STOP && trigActive && !maxEn
      && $stable(frameMode) |=> state_r == FT_ACQ || !trigMode)
      else $error("start-stop image split while trigger active");
   edge_start_a: assert property (
      state_r == FT_IDLE && trigMode && startEdge |=> state_r != FT_IDLE)
      else $error("selected edge did not start an image");
   fixed_length_a: assert property (
      state_r == FT_ACQ && frameMode == FRAME_START_ONLY && lineTick && lastLine
      |=> state_r == FT_IDLE && imageEnd_r)
      else $error("fixed-length image did not end on time");
   tail_end_a: assert property (
      state_r == FT_TAIL && lineTick && lineCnt_r == 16'h0001 |=> state_r == FT_IDLE)
      else $error("tail lines not ended");
   mode_off_a: assert property (!trigMode |=> state_r == FT_IDLE && !frameActive_r)
      else $error("framing active with triggered mode off");
   no_restart_a: assert property (
      imageStart_r |-> $past(state_r) == FT_IDLE || $past(state_r) == FT_DELAY)
      else $error("image restarted during acquisition");

endmodule

`default_nettype wire
